/* File: rtl/udpi_pkg.sv */
// Function
// - mask view holds one enable bit per source at fixed positions, except bus reset end (bit 12), which has none.
// - host resume mask bit is enabled after reset.
// - endpoint status rises when any endpoint flag becomes one.
// - endpoint status is sticky until firmware clears the endpoint flag.
// - suspend status set and suspend entered after 3 ms bus idle.
// - host resume status set when host resume signalling is seen.
// - in suspend, rising edge of send-resume sets external resume status.
// - external resume with remote wake enabled drives resume onto the bus.
// - start-of-frame status set on every frame start token.
// - end of bus reset sets status bit 12.
// - wakeup status set on host resume or bus reset since last clear.
// - writing one to clear register clears matching status bits 8 to 13; zero does nothing.
// - endpoint reset bit forces that endpoint fifo pointers to zero.
// - endpoint reset returns the data toggle to DATA0.
// - endpoint reset leaves flags alone; software writes the bit back to zero.
// - enable register sets mask bits, disable register clears them, on ones.
package udpi_pkg;
  localparam int NUM_EP = 4;
  localparam logic [7:0] OFS_IER = 8'h10;
  localparam logic [7:0] OFS_IDR = 8'h14;
  localparam logic [7:0] OFS_IMR = 8'h18;
  localparam logic [7:0] OFS_ISR = 8'h1C;
  localparam logic [7:0] OFS_ICR = 8'h20;
  localparam logic [7:0] OFS_RST_EP = 8'h28;
  localparam logic [7:0] OFS_CTRL = 8'h2C;
  localparam logic [7:0] OFS_STAT = 8'h30;
  localparam int BIT_SUSP = 8;
  localparam int BIT_HRSM = 9;
  localparam int BIT_XRSM = 10;
  localparam int BIT_SOF = 11;
  localparam int BIT_BRST = 12;
  localparam int BIT_WAKE = 13;
  localparam logic [31:0] MASK_BITS = 32'h0000_2F0F;
  localparam logic [31:0] STAT_BITS = 32'h0000_3F0F;
  localparam logic [31:0] CLR_BITS = 32'h0000_3F00;
  localparam logic [31:0] MASK_RST = 32'h0000_0200;
  localparam int CLK_MHZ = 250;
  localparam int IDLE_MS = 3;
  localparam int IDLE_CYC = IDLE_MS * 1000 * CLK_MHZ;
  localparam int RESUME_US = 10;
  localparam int RESUME_CYC = RESUME_US * CLK_MHZ;
  localparam int PTR_W = 11;

  typedef struct packed {
    logic activity;
    logic host_resume;
    logic sof_token;
    logic bus_reset_end;
  } udpi_bus_ev_t;

  typedef struct packed {
    logic setup_received_flag;
    logic bank0_received_flag;
    logic bank1_received_flag;
    logic transmit_complete_flag;
    logic stall_acked_flag;
  } udpi_ep_flags_t;

  function automatic logic udpi_any_flag(input udpi_ep_flags_t f);
    return |f;
  endfunction : udpi_any_flag
endpackage : udpi_pkg

/* File: rtl/udpi_sync.sv */
`timescale 1ns/10ps
module udpi_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  output logic dout
);
  import udpi_pkg::*;

  logic s1_r, s2_r, s3_r;
  // change accepted once the second and third stage agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) dout <= s3_r;
    end
  end
endmodule : udpi_sync

/* File: rtl/udpi_ep_ptr.sv */
`timescale 1ns/10ps
module udpi_ep_ptr #(
  parameter int PW = udpi_pkg::PTR_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ep_reset,
  input wire logic wr_push,
  input wire logic rd_pop,
  input wire logic toggle_flip,
  output logic [PW-1:0] byte_count,
  output logic data_toggle
);
  import udpi_pkg::*;

  logic [PW-1:0] wp_r, rp_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r <= '0;
      rp_r <= '0;
    end else if (ep_reset) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (wr_push) wp_r <= wp_r + 1'b1;
      if (rd_pop && wp_r != rp_r) rp_r <= rp_r + 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) data_toggle <= 1'b0;
    else if (ep_reset) data_toggle <= 1'b0;
    else if (toggle_flip) data_toggle <= ~data_toggle;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) byte_count <= '0;
    else if (ep_reset) byte_count <= '0;
    else byte_count <= wp_r - rp_r;
  end
endmodule : udpi_ep_ptr

/* File: rtl/udpi_top.sv */
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/10ps
module udpi_top #(
  parameter int IDLE_CYCLES = udpi_pkg::IDLE_CYC,
  parameter int RESUME_CYCLES = udpi_pkg::RESUME_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire udpi_pkg::udpi_bus_ev_t bus_ev,
  input wire udpi_pkg::udpi_ep_flags_t [udpi_pkg::NUM_EP-1:0] ep_flags,
  input wire logic [udpi_pkg::NUM_EP-1:0] ep_push,
  input wire logic [udpi_pkg::NUM_EP-1:0] ep_pop,
  input wire logic [udpi_pkg::NUM_EP-1:0] ep_toggle,
  input wire logic send_resume,
  output logic [udpi_pkg::NUM_EP*udpi_pkg::PTR_W-1:0] received_byte_count,
  output logic [udpi_pkg::NUM_EP-1:0] data_toggle,
  output logic [udpi_pkg::NUM_EP-1:0] endpoint_reset,
  output logic suspended,
  output logic resume_drive,
  output logic irq
);
  import udpi_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [31:0] mask_r;
  logic [31:0] stat_r;
  logic [NUM_EP-1:0] rst_ep_r;
  logic remote_wake_enable_r;
  logic susp_r;
  logic [31:0] idle_cnt_r;
  logic [31:0] rsm_cnt_r;
  logic sresume_s;
  logic sresume_d_r;
  logic [NUM_EP-1:0] ep_any;
  logic [NUM_EP-1:0] ep_any_d_r;
  logic wr_en;
  logic rd_en;
  logic [31:0] set_ev;
  logic [31:0] clr_ev;
  logic xrsm_ev;
  logic idle_hit;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;

  function automatic logic known_addr(input logic [7:0] a);
    return a == OFS_IER || a == OFS_IDR || a == OFS_IMR || a == OFS_ISR ||
           a == OFS_ICR || a == OFS_RST_EP || a == OFS_CTRL || a == OFS_STAT;
  endfunction : known_addr

  assign pslverr = psel && penable && !known_addr(paddr);

  ////////////////////////////////////////////////////////////////////////
  // send-resume is asynchronous to pclk
  udpi_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(send_resume),
    .dout(sresume_s)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sresume_d_r <= 1'b0;
    else sresume_d_r <= sresume_s;
  end

  assign xrsm_ev = susp_r && sresume_s && !sresume_d_r;

  ////////////////////////////////////////////////////////////////////////
  // bus idle timer
  assign idle_hit = !susp_r && idle_cnt_r == 32'(IDLE_CYCLES - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) idle_cnt_r <= '0;
    else if (bus_ev.activity || susp_r) idle_cnt_r <= '0;
    else if (!idle_hit) idle_cnt_r <= idle_cnt_r + 32'h0000_0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) susp_r <= 1'b0;
    else if (idle_hit) susp_r <= 1'b1;
    else if (bus_ev.activity || bus_ev.host_resume || resume_drive) susp_r <= 1'b0;
  end

  assign suspended = susp_r;

  // resume signalling toward the host, fixed length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rsm_cnt_r <= '0;
    else if (xrsm_ev && remote_wake_enable_r) rsm_cnt_r <= 32'(RESUME_CYCLES);
    else if (rsm_cnt_r != '0) rsm_cnt_r <= rsm_cnt_r - 32'h0000_0001;
  end

  assign resume_drive = rsm_cnt_r != '0;

  ////////////////////////////////////////////////////////////////////////
  // endpoint flag edges
  always_comb begin
    for (int i = 0; i < NUM_EP; i++) ep_any[i] = udpi_any_flag(ep_flags[i]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ep_any_d_r <= '0;
    else ep_any_d_r <= ep_any;
  end

  always_comb begin
    set_ev = '0;
    set_ev[BIT_SUSP] = idle_hit;
    set_ev[BIT_HRSM] = bus_ev.host_resume;
    set_ev[BIT_XRSM] = xrsm_ev;
    set_ev[BIT_SOF] = bus_ev.sof_token;
    set_ev[BIT_BRST] = bus_ev.bus_reset_end;
    set_ev[BIT_WAKE] = bus_ev.host_resume || bus_ev.bus_reset_end;
    clr_ev = (wr_en && paddr == OFS_ICR) ? (pwdata & CLR_BITS) : '0;
  end

  // set wins over a simultaneous clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) stat_r <= '0;
    else stat_r <= ((stat_r & ~clr_ev) | set_ev) & STAT_BITS;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mask_r <= MASK_RST;
    else if (wr_en && paddr == OFS_IER) mask_r <= mask_r | (pwdata & MASK_BITS);
    else if (wr_en && paddr == OFS_IDR) mask_r <= mask_r & ~(pwdata & MASK_BITS);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rst_ep_r <= '0;
    else if (wr_en && paddr == OFS_RST_EP) rst_ep_r <= pwdata[NUM_EP-1:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) remote_wake_enable_r <= 1'b0;
    else if (wr_en && paddr == OFS_CTRL) remote_wake_enable_r <= pwdata[0];
  end

  assign endpoint_reset = rst_ep_r;

  ////////////////////////////////////////////////////////////////////////
  // endpoint status follows the live flags, so it stays until they clear
  logic [31:0] view_stat;
  always_comb begin
    view_stat = stat_r;
    view_stat[NUM_EP-1:0] = ep_any_d_r | ep_any;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq <= 1'b0;
    else irq <= |(view_stat & mask_r);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= '0;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        OFS_IMR: prdata <= mask_r & MASK_BITS;
        OFS_ISR: prdata <= view_stat;
        OFS_RST_EP: prdata <= {28'h000_0000, rst_ep_r};
        OFS_CTRL: prdata <= {31'h0000_0000, remote_wake_enable_r};
        OFS_STAT: prdata <= {31'h0000_0000, susp_r};
        default: prdata <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : g_ep
      udpi_ep_ptr u_ptr (
        .pclk(pclk),
        .presetn(presetn),
        .ep_reset(rst_ep_r[g]),
        .wr_push(ep_push[g]),
        .rd_pop(ep_pop[g]),
        .toggle_flip(ep_toggle[g]),
        .byte_count(received_byte_count[g*PTR_W +: PTR_W]),
        .data_toggle(data_toggle[g])
      );
    end
  endgenerate
endmodule : udpi_top

/* File: tb/udpi_chk.sv */
`timescale 1ns/10ps
module udpi_chk import udpi_pkg::*; #(
  parameter int IDLE_CYCLES = 50
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire udpi_pkg::udpi_bus_ev_t bus_ev,
  input wire logic [udpi_pkg::NUM_EP*udpi_pkg::PTR_W-1:0] received_byte_count,
  input wire logic [udpi_pkg::NUM_EP-1:0] data_toggle,
  input wire logic [udpi_pkg::NUM_EP-1:0] endpoint_reset,
  input wire logic suspended,
  input wire logic resume_drive
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] idle_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_r <= '0;
    end else if (bus_ev.activity) begin
      idle_r <= '0;
    end else begin
      idle_r <= idle_r + 32'h0000_0001;
    end
  end
  sequence rd_acc(a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  sequence ep_zero_rst;
    $past(endpoint_reset[0]) && endpoint_reset[0];
  endsequence
  ////////////////////////////////////////
  a_imr_bits: assert property (rd_acc(OFS_IMR) |-> (prdata & ~MASK_BITS) == '0)
    else $error("mask view shows a reserved bit");
  a_rst_view: assert property (rd_acc(OFS_RST_EP) |-> prdata == {28'h0, endpoint_reset})
    else $error("endpoint reset readback differs");
  a_ptr0_zero: assert property (ep_zero_rst |-> received_byte_count[10:0] == '0)
    else $error("endpoint zero count not zero in reset");
  a_ptr3_zero: assert property ($past(endpoint_reset[3]) && endpoint_reset[3]
    |-> received_byte_count[43:33] == '0)
    else $error("endpoint three count not zero in reset");
  a_tog_data0: assert property (ep_zero_rst |-> data_toggle[0] == 1'b0)
    else $error("endpoint zero toggle not DATA0 in reset");
  a_susp_idle: assert property ($rose(suspended) |-> idle_r >= IDLE_CYCLES - 2)
    else $error("suspend entered too early");
  a_wake_susp: assert property ($rose(resume_drive) |-> $past(suspended))
    else $error("resume driven outside suspend");
  a_wake_len: assert property ($rose(resume_drive) |-> resume_drive [*8])
    else $error("resume drive too short");
endmodule : udpi_chk
bind udpi_top udpi_chk #(.IDLE_CYCLES(IDLE_CYCLES)) udpi_chk_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .bus_ev(bus_ev), .received_byte_count(received_byte_count),
  .data_toggle(data_toggle), .endpoint_reset(endpoint_reset), .suspended(suspended),
  .resume_drive(resume_drive));

/* File: tb/udpi_host.sv */
`timescale 1ns/10ps
module udpi_host import udpi_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic quiet,
  input wire udpi_pkg::udpi_bus_ev_t req,
  output udpi_pkg::udpi_bus_ev_t bus_ev
);
  logic [2:0] gap_r;
  // traffic every 8 cycles keeps the port awake; quiet lets the idle timer run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r <= '0;
      bus_ev <= '0;
    end else begin
      gap_r <= gap_r + 3'h1;
      // one assignment per edge: keep-alive traffic merged into the activity bit
      bus_ev <= req | {(!quiet && gap_r == 3'h0), 3'h0};
    end
  end
endmodule : udpi_host

/* File: tb/test_udpi_top.sv */
`timescale 1ns/10ps
module test_udpi_top;
  import udpi_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, quiet = 0, send_resume = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rv;
  logic pready, pslverr, suspended, resume_drive, irq, err;
  udpi_bus_ev_t bus_ev, ev = '0;
  udpi_ep_flags_t [NUM_EP-1:0] ep_flags = '0;
  logic [NUM_EP-1:0] ep_push = '0, ep_pop = '0, ep_toggle = '0, data_toggle, endpoint_reset;
  logic [NUM_EP*PTR_W-1:0] received_byte_count;
  int error_cnt = 0, checked = 0, n;
  always #2 pclk = ~pclk;
  udpi_top #(.IDLE_CYCLES(50), .RESUME_CYCLES(10)) udpi_top_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_ev(bus_ev),
    .ep_flags(ep_flags), .ep_push(ep_push), .ep_pop(ep_pop), .ep_toggle(ep_toggle),
    .send_resume(send_resume), .received_byte_count(received_byte_count),
    .data_toggle(data_toggle), .endpoint_reset(endpoint_reset), .suspended(suspended),
    .resume_drive(resume_drive), .irq(irq));
  udpi_host udpi_host_inst (.pclk(pclk), .presetn(presetn), .quiet(quiet), .req(ev),
    .bus_ev(bus_ev));
  ////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic bail(input logic ok);
    chk("wait", 1, ok);
    if (ok !== 1'b1) tally_and_finish();
  endtask : bail
  // idle cycle first, so psel is never lowered and raised in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    bail(k < 16);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rv);
  endtask : rd
  // one pulse per call; an edge separates the release from the next pulse
  task automatic host(input udpi_bus_ev_t e);
    @(posedge pclk);
    ev <= e;
    @(posedge pclk);
    ev <= '0;
  endtask : host
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd("imr", OFS_IMR, MASK_RST);
    wr(OFS_ICR, 32'h0000_3F00);
    rd("isr", OFS_ISR, 32'h0);
    wr(OFS_IER, 32'hFFFF_FFFF);
    rd("imr", OFS_IMR, MASK_BITS);
    wr(OFS_IDR, 32'h0000_0F0E);
    rd("imr", OFS_IMR, 32'h0000_2001);
    host(4'h2);
    host(4'h1);
    host(4'h4);
    rd("isr", OFS_ISR, 32'h0000_3A00);
    chk("irq", 1, irq);
    wr(OFS_ICR, 32'h0);
    rd("isr", OFS_ISR, 32'h0000_3A00);
    wr(OFS_ICR, 32'h0000_0800);
    rd("isr", OFS_ISR, 32'h0000_3200);
    wr(OFS_ICR, 32'h0000_3200);
    rd("isr", OFS_ISR, 32'h0);
    chk("irq", 0, irq);
    for (int i = 0; i < 5; i++) begin
      ep_flags[2] <= udpi_ep_flags_t'(5'h1 << i);
      rd("isr_ep", OFS_ISR, 32'h4);
      chk("irq", 0, irq);
      rd("isr_ep", OFS_ISR, 32'h4);
      ep_flags[2] <= '0;
      @(posedge pclk);
      rd("isr_ep", OFS_ISR, 32'h0);
    end
    ep_flags[0] <= udpi_ep_flags_t'(5'h10);
    ep_push <= 4'h9;
    ep_toggle <= 4'h1;
    @(posedge pclk);
    ep_toggle <= 4'h0;
    repeat (2) @(posedge pclk);
    ep_push <= 4'h0;
    ep_pop <= 4'h1;
    @(posedge pclk);
    ep_pop <= 4'h0;
    @(posedge pclk);
    #1;
    chk("cnt0", 2, received_byte_count[10:0]);
    chk("cnt3", 3, received_byte_count[43:33]);
    chk("tgl0", 1, data_toggle[0]);
    chk("irq", 1, irq);
    wr(OFS_RST_EP, 32'h9);
    rd("rst", OFS_RST_EP, 32'h9);
    chk("cnt0", 0, received_byte_count[10:0]);
    chk("cnt3", 0, received_byte_count[43:33]);
    chk("tgl0", 0, data_toggle[0]);
    rd("isr_ep", OFS_ISR, 32'h1);
    wr(OFS_RST_EP, 32'h0);
    rd("rst", OFS_RST_EP, 32'h0);
    ep_flags[0] <= '0;
    quiet <= 1'b1;
    for (n = 0; n < 200 && suspended !== 1'b1; n++) @(posedge pclk);
    bail(suspended);
    rd("stat", OFS_STAT, 32'h1);
    rd("isr", OFS_ISR, 32'h0000_0100);
    wr(OFS_CTRL, 32'h1);
    rd("ctrl", OFS_CTRL, 32'h1);
    send_resume <= 1'b1;
    for (n = 0; n < 40 && resume_drive !== 1'b1; n++) @(posedge pclk);
    bail(resume_drive);
    rd("isr", OFS_ISR, 32'h0000_0500);
    rd("gap", 8'h40, 32'h0);
    chk("slverr", 1, err);
    tally_and_finish();
  end
endmodule : test_udpi_top
